//--- sysctl_chk_asserts.sv
/*
 port checker for the system control register bank.
 assumes the bank's port names and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module sysctl_chk
   import sysctl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic global_peripheral_irq_en_i,
   input wire logic comparator_pend_i,
   input wire logic wide_timer_overflow_pend_i,
   input wire logic comparator_req_o,
   input wire logic wide_timer_overflow_req_o,
   input wire logic [TRIM_W-1:0] trim_code_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // read data against register layout
   a_enable_holes_zero: assert property (rd_i && addr_i == OFS_PERIPHERAL_IRQ_ENABLE |=>
      (rdata_o & ~ENABLE_MASK) == 8'h00) else $error("enable hole bits set");
   a_cause_holes_zero: assert property (rd_i && addr_i == OFS_RESET_CAUSE_FLAGS |=>
      rdata_o[7:2] == 6'h00) else $error("cause hole bits set");
   a_trim_read_back: assert property (rd_i && addr_i == OFS_OSCILLATOR_TRIM |=>
      rdata_o == {trim_code_o, 2'b00}) else $error("trim read mismatch");
   a_gap_reads_zero: assert property (rd_i && addr_i == 8'h8d |=>
      rdata_o == 8'h00) else $error("unmapped read not zero");
   // trim write reaches oscillator
   a_trim_write_code: assert property (wr_i && addr_i == OFS_OSCILLATOR_TRIM |=>
      {trim_code_o, 2'b00} == ($past(wdata_i) & 8'hfc)) else $error("trim not loaded");
   // request gating
   a_cmp_req_cause: assert property (comparator_req_o |-> $past(comparator_pend_i) &&
      $past(global_peripheral_irq_en_i)) else $error("comparator request ungated");
   a_tmr_req_cause: assert property (wide_timer_overflow_req_o |->
      $past(wide_timer_overflow_pend_i)) else $error("timer request without pending");
   a_global_low_quiet: assert property (!global_peripheral_irq_en_i |=>
      !comparator_req_o && !wide_timer_overflow_req_o) else $error("request without global");
   c_cmp_req: cover property (comparator_req_o);
   c_trim_wr: cover property (wr_i && addr_i == OFS_OSCILLATOR_TRIM);
   c_cause_rd: cover property (rd_i && addr_i == OFS_RESET_CAUSE_FLAGS);
endmodule
bind system_control_register_bank sysctl_chk u_chk (.*);
`default_nettype wire

//--- sysctl_pkg.sv
/*
 holds register offsets, field positions and reset values for the
 system control register bank.
 assumes an 8-bit register port with byte addresses from 8'h8c to 8'h92, in the upper half of the space.
*/
package sysctl_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [7:0] OFS_PERIPHERAL_IRQ_ENABLE = 8'h8c;
   localparam logic [7:0] OFS_RESET_CAUSE_FLAGS = 8'h8e;
   localparam logic [7:0] OFS_OSCILLATOR_TRIM = 8'h90;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h91;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h92;
   // enable register fields
   localparam int BIT_NVM_DONE = 7;
   localparam int BIT_CONV_DONE = 6;
   localparam int BIT_COMPARATOR = 3;
   localparam int BIT_TIMER_OVF = 0;
   localparam logic [7:0] ENABLE_MASK = 8'hc9;
   // reset-cause fields
   localparam int BIT_POWER_ON = 1;
   localparam int BIT_BROWNOUT = 0;
   localparam logic [7:0] CAUSE_MASK = 8'h03;
   // trim field
   localparam int TRIM_LSB = 2;
   localparam int TRIM_W = 6;
   localparam logic [5:0] TRIM_CENTER = 6'h20;
   // event status bits
   localparam int EV_BROWNOUT = 0;
   localparam int EV_W = 1;
   // reset values
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [1:0] CAUSE_RST = 2'h0;
endpackage

//--- system_control_register_bank.sv
/*
 system control register bank: peripheral interrupt enables, reset-cause
 flags, oscillator trim, plus a brown-out event status/mask pair.
 assumes rst_i is the power-on reset, and that all inputs are synchronous
 to mclk_i; pending flags and the global enable live elsewhere.
*/
// Operation
// RULE1 - three registers at three separate addresses
// RULE2 - bit 7 gates nvm write-done request
// RULE3 - bit 6 gates conversion-done request
// RULE4 - bit 3 gates comparator request
// RULE5 - bit 0 gates timer overflow request
// RULE6 - global peripheral enable must also be set
// RULE7 - unimplemented bits always read zero
// RULE8 - power-on flag zero after power-on reset
// RULE9 - brown-out event clears brown-out flag
// RULE10 - six-bit trim field drives oscillator
// RULE11 - trim code monotonic, centre is 100000
// RULE12 - reset clears enables, loads centre trim
// RULE13 - request is flag AND enable AND global
`timescale 1ns/1ps
`default_nettype none
module system_control_register_bank
   import sysctl_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DATA_W-1:0] rdata_o,
   input wire logic global_peripheral_irq_en_i,
   input wire logic nvm_write_done_pend_i,
   input wire logic conversion_done_pend_i,
   input wire logic comparator_pend_i,
   input wire logic wide_timer_overflow_pend_i,
   input wire logic brownout_event_i,
   output logic nvm_write_done_req_o,
   output logic conversion_done_req_o,
   output logic comparator_req_o,
   output logic wide_timer_overflow_req_o,
   output logic [TRIM_W-1:0] trim_code_o,
   output logic irq_o
);
   logic [7:0] peripheral_irq_enable;
   logic [7:0] next_peripheral_irq_enable;
   logic [1:0] reset_cause_flags;
   logic [1:0] next_reset_cause_flags;
   logic [TRIM_W-1:0] trim_code;
   logic [TRIM_W-1:0] next_trim_code;
   logic [EV_W-1:0] irq_status;
   logic [EV_W-1:0] next_irq_status;
   logic [EV_W-1:0] irq_mask;
   logic [EV_W-1:0] next_irq_mask;
   logic [DATA_W-1:0] next_rdata;
   // one slot per gated peripheral source, slot 0 is the timer
   localparam int NUM_REQ = 4;
   localparam int REQ_BIT [NUM_REQ] = '{BIT_TIMER_OVF, BIT_COMPARATOR, BIT_CONV_DONE,
      BIT_NVM_DONE};
   logic [NUM_REQ-1:0] pend;
   logic [NUM_REQ-1:0] next_req;
   logic next_irq;
   logic wr_enable;
   logic wr_cause;
   logic wr_trim;
   logic wr_status;
   logic wr_mask;

   // address decode
   always_comb begin
      wr_enable = wr_i && (addr_i == OFS_PERIPHERAL_IRQ_ENABLE); // RULE1
      wr_cause = wr_i && (addr_i == OFS_RESET_CAUSE_FLAGS); // RULE1
      wr_trim = wr_i && (addr_i == OFS_OSCILLATOR_TRIM); // RULE1
      wr_status = wr_i && (addr_i == OFS_IRQ_STATUS);
      wr_mask = wr_i && (addr_i == OFS_IRQ_MASK);
   end

   // register next values
   always_comb begin
      next_peripheral_irq_enable = peripheral_irq_enable;
      if (wr_enable) begin
         next_peripheral_irq_enable = wdata_i & ENABLE_MASK; // RULE7
      end
      next_reset_cause_flags = reset_cause_flags;
      if (wr_cause) begin
         next_reset_cause_flags = wdata_i[1:0]; // RULE8
      end
      if (brownout_event_i) begin
         next_reset_cause_flags[BIT_BROWNOUT] = 1'b0; // RULE9
      end
      next_trim_code = trim_code;
      if (wr_trim) begin
         next_trim_code = wdata_i[TRIM_LSB +: TRIM_W]; // RULE10
      end
      next_irq_mask = irq_mask;
      if (wr_mask) begin
         next_irq_mask = wdata_i[EV_W-1:0];
      end
      // write one clears, a new event wins over the clear
      next_irq_status = irq_status;
      if (wr_status) begin
         next_irq_status = irq_status & ~wdata_i[EV_W-1:0];
      end
      if (brownout_event_i) begin
         next_irq_status[EV_BROWNOUT] = 1'b1;
      end
   end

   // read mux, data valid the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      if (rd_i) begin
         unique case (addr_i)
            OFS_PERIPHERAL_IRQ_ENABLE: next_rdata = peripheral_irq_enable & ENABLE_MASK; // RULE7
            OFS_RESET_CAUSE_FLAGS: next_rdata = {6'h00, reset_cause_flags}; // RULE7
            OFS_OSCILLATOR_TRIM: next_rdata = {trim_code, 2'h0}; // RULE7
            OFS_IRQ_STATUS: next_rdata = {7'h00, irq_status};
            OFS_IRQ_MASK: next_rdata = {7'h00, irq_mask};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // pending flags gathered in request slot order
   assign pend = {nvm_write_done_pend_i, conversion_done_pend_i, comparator_pend_i,
      wide_timer_overflow_pend_i};

   // gated peripheral requests, one slot per source
   // the enable's next value is used so a write and its effect land on one edge
   for (genvar ch = 0; ch < NUM_REQ; ch++) begin : g_req
      always_comb begin
         next_req[ch] = pend[ch] && next_peripheral_irq_enable[REQ_BIT[ch]]
            && global_peripheral_irq_en_i; // RULE2 RULE3 RULE4 RULE5 RULE6 RULE13
      end
   end

   // interrupt level follows unmasked event status
   always_comb begin
      next_irq = |(next_irq_status & next_irq_mask);
   end

   // state registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         peripheral_irq_enable <= ENABLE_RST; // RULE12
         reset_cause_flags <= CAUSE_RST; // RULE8 RULE12
         trim_code <= TRIM_CENTER; // RULE11 RULE12
         irq_status <= '0;
         irq_mask <= '0;
         rdata_o <= 8'h00;
         nvm_write_done_req_o <= 1'b0;
         conversion_done_req_o <= 1'b0;
         comparator_req_o <= 1'b0;
         wide_timer_overflow_req_o <= 1'b0;
         trim_code_o <= TRIM_CENTER;
         irq_o <= 1'b0;
      end else begin
         peripheral_irq_enable <= next_peripheral_irq_enable;
         reset_cause_flags <= next_reset_cause_flags;
         trim_code <= next_trim_code;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
         rdata_o <= next_rdata;
         nvm_write_done_req_o <= next_req[3];
         conversion_done_req_o <= next_req[2];
         comparator_req_o <= next_req[1];
         wide_timer_overflow_req_o <= next_req[0];
         trim_code_o <= next_trim_code; // RULE10 RULE11
         irq_o <= next_irq;
      end
   end
endmodule
`default_nettype wire

//--- system_control_register_bank_tb.sv
/*
 self-checking bench for the system control register bank.
 assumes one 50 ns clock and the one-cycle register port.
*/
`timescale 1ns/1ps
`default_nettype none
module system_control_register_bank_tb;
   import sysctl_pkg::*;
   logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, g = 0, bo = 0, irq_o;
   logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, a, m[logic [7:0]];
   logic [3:0] pd = 0, rq;
   logic [7:0] e;
   logic [5:0] trim_code_o;
   int num_errors = 0, num_checks = 0;
   system_control_register_bank dut (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
      .global_peripheral_irq_en_i(g), .nvm_write_done_pend_i(pd[3]),
      .conversion_done_pend_i(pd[2]), .comparator_pend_i(pd[1]),
      .wide_timer_overflow_pend_i(pd[0]), .brownout_event_i(bo), .nvm_write_done_req_o(rq[3]),
      .conversion_done_req_o(rq[2]), .comparator_req_o(rq[1]), .wide_timer_overflow_req_o(rq[0]),
      .trim_code_o, .irq_o);
   initial forever #25 mclk_i = ~mclk_i;
   // compare and count
   task chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
      end
   endtask
   // one-cycle write, then model update
   task wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge mclk_i) {addr_i, wdata_i, wr_i} <= {ad, d, 1'b1};
      @(posedge mclk_i) wr_i <= 0;
      if (ad == 8'h91) m[ad] &= ~d;
      else if (m.exists(ad)) m[ad] = d & (ad == 8'h8c ? ENABLE_MASK : ad == 8'h8e ? CAUSE_MASK :
         ad == 8'h90 ? 8'hfc : 8'h01);
   endtask
   // one-cycle read, data checked in the following cycle
   task rd(input logic [7:0] ad);
      @(posedge mclk_i) {addr_i, rd_i} <= {ad, 1'b1};
      @(posedge mclk_i) rd_i <= 0;
      #1 chk(rdata_o, m.exists(ad) ? m[ad] : 8'h00);
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000 num_errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(32'h2321));
      m[8'h8c] = 0; m[8'h8e] = 0; m[8'h90] = 8'h80; m[8'h91] = 0; m[8'h92] = 0;
      repeat (6) @(posedge mclk_i);
      rst_i <= 0;
      foreach (m[k]) rd(k);
      chk({2'b00, trim_code_o}, {2'b00, TRIM_CENTER});
      $display("test 1 done");
      repeat (30) begin
         a = 8'h8c + 8'($urandom % 7);
         wr(a, 8'($urandom));
         rd(a);
         chk({2'b00, trim_code_o}, m[8'h90] >> 2);
      end
      $display("test 2 done");
      for (int i = 0; i < 32; i++) begin
         wr(8'h8c, 8'($urandom));
         @(posedge mclk_i) {g, pd} <= i[4:0];
         repeat (2) @(posedge mclk_i);
         e = {4'h0, pd & {m[8'h8c][7:6], m[8'h8c][3], m[8'h8c][0]} & {4{g}}};
         #1 chk({4'h0, rq}, e);
      end
      $display("test 3 done");
      wr(8'h92, 8'h01);
      wr(8'h8e, 8'h03);
      @(posedge mclk_i) bo <= 1;
      @(posedge mclk_i) bo <= 0;
      m[8'h8e] &= 8'h02;
      m[8'h91] |= 8'h01;
      @(posedge mclk_i) #1 chk({7'h0, irq_o}, 8'h01);
      rd(8'h8e);
      rd(8'h91);
      wr(8'h91, 8'h01);
      @(posedge mclk_i) #1 chk({7'h0, irq_o}, 8'h00);
      $display("test 4 done");
      give_verdict();
   end
endmodule
`default_nettype wire
